// >>> src/hspc_params.svh
/*
 Offsets, field positions, reset values and timing counts of the hot-swap
 supervision block. Assumes inclusion by bare name from the design files.
*/
`ifndef HSPC_PARAMS_SVH
`define HSPC_PARAMS_SVH

// ****************************************
// Command codes
// ****************************************
`define HSPC_CMD_OPERATION 8'h03
`define HSPC_CMD_CLEAR_FAULTS 8'h04
`define HSPC_CMD_OT_FAULT 8'h4f
`define HSPC_CMD_OT_WARN 8'h51
`define HSPC_CMD_VENDOR_STATUS 8'h80
`define HSPC_CMD_TEMPERATURE 8'h8d
`define HSPC_CMD_ALERT_MASK 8'hd8
`define HSPC_CMD_DEVICE_SETUP 8'hd9
`define HSPC_CMD_DIAG_WORD 8'he1

// ****************************************
// Reset values and operation codes
// ****************************************
`define HSPC_OP_ON 8'h80
`define HSPC_OP_OFF 8'h00
`define HSPC_RST_OPERATION 8'h80
`define HSPC_RST_OT_WARN 16'h007d
`define HSPC_RST_OT_FAULT 16'h0096
`define HSPC_RST_ALERT_MASK 16'h0000
`define HSPC_RST_DEVICE_SETUP 8'h06
`define HSPC_ADDR_BASE 7'h40

// ****************************************
// Field positions
// ****************************************
`define HSPC_VS_SHORTED_BIT 7
`define HSPC_DW_SHORTED_BIT 15
`define HSPC_DW_OT_WARN_BIT 14
`define HSPC_DW_OT_FAULT_BIT 13
`define HSPC_DW_LATCHED_BIT 12
`define HSPC_DW_UV_BIT 11
`define HSPC_DW_OV_BIT 10
`define HSPC_MASK_SHORTED_BIT 7
`define HSPC_MASK_OT_WARN_BIT 6
`define HSPC_SETUP_RETRY_LSB 0

// ****************************************
// Timing
// ****************************************
`define HSPC_CLK_PERIOD_NS 25
`define HSPC_TEMP_PERIOD_NS 1000000
`define HSPC_TEMP_PERIOD_CYCLES (`HSPC_TEMP_PERIOD_NS / `HSPC_CLK_PERIOD_NS)

`endif

// >>> src/hspc_pkg.sv
/*
 Types shared by the hot-swap supervision block.
 Assumes nothing of its surroundings.
*/
package hspc_pkg;

  // ****************************************
  // Pin bundle and bus states
  // ****************************************
  typedef struct packed {
    logic en;
    logic ov;
    logic vref;
    logic sense;
    logic gateLow;
    logic trip;
    logic scl;
    logic sda;
    logic [1:0] strap0;
    logic [1:0] strap1;
    logic [1:0] strap2;
  } hspc_pins_s;

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_RX,
    BUS_RXACK,
    BUS_TX,
    BUS_TXACK
  } hspc_bus_e;

endpackage

// >>> src/hspc_ms_tick.sv
/*
 Sample cadence: one tick and one diode current pulse per sample period.
 Assumes one clock; reset is synchronous, active low.
*/
`timescale 1ns/1ps
`include "hspc_params.svh"

module hspc_ms_tick #(
  parameter int PERIOD_CYCLES = `HSPC_TEMP_PERIOD_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  output logic tick,
  output logic diodePulse
);

  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic tick_reg;
  logic tick_next;

  always_comb begin
    count_next = count_reg + 32'h1;
    tick_next = 1'b0;
    if (count_reg == 32'(PERIOD_CYCLES - 1)) begin
      count_next = 32'h0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      count_reg <= 32'h0;
      tick_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
  assign diodePulse = tick_reg;

  chk_tick_spacing: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tick_reg |=> !tick_reg [*2]) else $error("sample tick repeated too soon");

endmodule

// >>> src/hspc_top.sv
/*
 Hot-swap supervision and control logic with its SMBus command slave.
 Assumes comparator and strap pins arrive asynchronously, temperature codes
 arrive from the analog front end on sys_clk, and SDA/SMBA are open drain.
*/
// How it works
// - Pulse diode current once per millisecond
// - Temperature command returns latest sample
// - Alert low above warning threshold
// - Gate off above fault threshold
// - Host rewrites warning and fault thresholds
// - Sense high with gate low flags short
// - Short drives alert unless masked
// - Enable low or overvoltage forces gate off
// - Enable toggle leaves latched-off state
// - Settings survive enable and overvoltage pins
// - Operation on enables, zero disables
// - Ternary straps latched into bus address
// - Reference low holds reset, clears settings
// - Address latched after reference rises
// - Retry count selectable, then latch off
`timescale 1ns/1ps
`include "hspc_params.svh"

module hspc_top #(
  parameter int TEMP_PERIOD_CYCLES = `HSPC_TEMP_PERIOD_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic sclPin,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic smbaOut,
  output logic smbaOe,
  input wire logic undervoltEnablePin,
  input wire logic overvoltLockoutPin,
  input wire logic vrefAboveCapture,
  input wire logic [1:0] addrStrapBit0,
  input wire logic [1:0] addrStrapBit1,
  input wire logic [1:0] addrStrapBit2,
  input wire logic senseAboveShort,
  input wire logic gateIsLow,
  input wire logic timerTrip,
  input wire logic [15:0] tempSample,
  input wire logic tempSampleValid,
  output logic diodePulse,
  output logic gateDrive,
  output logic latchedOff,
  output logic [6:0] busAddr
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  hspc_pkg::hspc_pins_s pinsRaw;
  hspc_pkg::hspc_pins_s pinsMeta;
  hspc_pkg::hspc_pins_s pinsSync;
  hspc_pkg::hspc_pins_s pinsPrev;

  assign pinsRaw = '{en: undervoltEnablePin, ov: overvoltLockoutPin, vref: vrefAboveCapture,
    sense: senseAboveShort, gateLow: gateIsLow, trip: timerTrip, scl: sclPin, sda: sdaIn,
    strap0: addrStrapBit0, strap1: addrStrapBit1, strap2: addrStrapBit2};

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      // Bus pins start at their idle high level, so no false edge follows reset
      pinsMeta <= '{scl: 1'b1, sda: 1'b1, default: '0};
      pinsSync <= '{scl: 1'b1, sda: 1'b1, default: '0};
      pinsPrev <= '{scl: 1'b1, sda: 1'b1, default: '0};
    end else begin
      pinsMeta <= pinsRaw;
      pinsSync <= pinsMeta;
      pinsPrev <= pinsSync;
    end
  end

  hspc_ms_tick #(.PERIOD_CYCLES(TEMP_PERIOD_CYCLES)) hspc_ms_tick_inst (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tick(),
    .diodePulse(diodePulse)
  );

  // ****************************************
  // Register file and protection state
  // ****************************************
  logic [7:0] operation_reg, operation_next;
  logic [15:0] otFault_reg, otFault_next;
  logic [15:0] otWarn_reg, otWarn_next;
  logic [15:0] alertMask_reg, alertMask_next;
  logic [7:0] setup_reg, setup_next;
  logic [15:0] temp_reg, temp_next;
  logic shorted_reg, shorted_next;
  logic latched_reg, latched_next;
  logic [4:0] retries_reg, retries_next;
  logic addrValid_reg, addrValid_next;
  logic [6:0] addr_reg, addr_next;
  logic gate_reg, gate_next;
  logic smba_reg, smba_next;
  logic otWarn, otFault, shortCond, enRise, tripRise, retryExhausted;
  logic wrStrobe, clearStrobe;
  logic [7:0] wrCmd;
  logic [15:0] wrData;
  logic [2:0] retryCode;

  // Retry code 0..5 gives 0,1,2,4,8,16 retries; 6 and 7 retry forever
  function automatic logic exhausted(input logic [2:0] code, input logic [4:0] used);
    logic [4:0] limit;
    limit = 5'h0;
    case (code)
      3'h0: limit = 5'h0;
      3'h1: limit = 5'h1;
      3'h2: limit = 5'h2;
      3'h3: limit = 5'h4;
      3'h4: limit = 5'h8;
      default: limit = 5'h10;
    endcase
    exhausted = (code < 3'h6) && (used >= limit);
  endfunction

  assign otWarn = temp_reg > otWarn_reg;
  assign otFault = temp_reg > otFault_reg;
  assign shortCond = pinsSync.sense && (pinsSync.gateLow || !gate_reg);
  assign enRise = pinsSync.en && !pinsPrev.en;
  assign tripRise = pinsSync.trip && !pinsPrev.trip;
  assign retryCode = setup_reg[`HSPC_SETUP_RETRY_LSB +: 3];
  assign retryExhausted = exhausted(retryCode, retries_reg);

  always_comb begin
    operation_next = operation_reg;
    otFault_next = otFault_reg;
    otWarn_next = otWarn_reg;
    alertMask_next = alertMask_reg;
    setup_next = setup_reg;
    temp_next = temp_reg;
    shorted_next = shorted_reg;
    latched_next = latched_reg;
    retries_next = retries_reg;
    addrValid_next = addrValid_reg;
    addr_next = addr_reg;
    if (tempSampleValid) begin
      temp_next = tempSample;
    end
    // Writes touch only host registers; pins never reach them
    if (wrStrobe) begin
      if (wrCmd == `HSPC_CMD_OPERATION) begin
        operation_next = wrData[7:0];
      end else if (wrCmd == `HSPC_CMD_OT_FAULT) begin
        otFault_next = wrData;
      end else if (wrCmd == `HSPC_CMD_OT_WARN) begin
        otWarn_next = wrData;
      end else if (wrCmd == `HSPC_CMD_ALERT_MASK) begin
        alertMask_next = wrData;
      end else if (wrCmd == `HSPC_CMD_DEVICE_SETUP) begin
        setup_next = wrData[7:0];
      end
    end
    if (clearStrobe) begin
      shorted_next = 1'b0;
    end
    // Set beats a clear in the same cycle
    if (shortCond) begin
      shorted_next = 1'b1;
    end
    if (enRise) begin
      latched_next = 1'b0;
      retries_next = 5'h0;
    end
    // A trip beats an enable edge in the same cycle unless already latched off
    if (tripRise && !latched_reg) begin
      if (retryExhausted) begin
        latched_next = 1'b1;
      end else begin
        retries_next = retries_reg + 5'h1;
      end
    end
    // Straps read only after reference is up, once per reset
    if (!addrValid_reg && pinsSync.vref) begin
      addrValid_next = 1'b1;
      addr_next = `HSPC_ADDR_BASE + 7'(pinsSync.strap2 * 5'd9 + pinsSync.strap1 * 5'd3 + pinsSync.strap0);
    end
    gate_next = (operation_reg == `HSPC_OP_ON) && !latched_next &&
      pinsSync.en && !pinsSync.ov &&
      !otFault;
    smba_next = (otWarn && !alertMask_reg[`HSPC_MASK_OT_WARN_BIT]) ||
      (shorted_reg && !alertMask_reg[`HSPC_MASK_SHORTED_BIT]);
  end

  // Reset is the reference-low reset: every setting returns here
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      operation_reg <= `HSPC_RST_OPERATION;
      otFault_reg <= `HSPC_RST_OT_FAULT;
      otWarn_reg <= `HSPC_RST_OT_WARN;
      alertMask_reg <= `HSPC_RST_ALERT_MASK;
      setup_reg <= `HSPC_RST_DEVICE_SETUP;
      temp_reg <= 16'h0000;
      shorted_reg <= 1'b0;
      latched_reg <= 1'b0;
      retries_reg <= 5'h0;
      addrValid_reg <= 1'b0;
      addr_reg <= 7'h00;
      gate_reg <= 1'b0;
      smba_reg <= 1'b0;
    end else begin
      operation_reg <= operation_next;
      otFault_reg <= otFault_next;
      otWarn_reg <= otWarn_next;
      alertMask_reg <= alertMask_next;
      setup_reg <= setup_next;
      temp_reg <= temp_next;
      shorted_reg <= shorted_next;
      latched_reg <= latched_next;
      retries_reg <= retries_next;
      addrValid_reg <= addrValid_next;
      addr_reg <= addr_next;
      gate_reg <= gate_next;
      smba_reg <= smba_next;
    end
  end

  assign gateDrive = gate_reg;
  assign latchedOff = latched_reg;
  assign busAddr = addr_reg;
  assign smbaOut = 1'b0;
  assign smbaOe = smba_reg;

  // ****************************************
  // SMBus slave
  // ****************************************
  hspc_pkg::hspc_bus_e bus_reg, bus_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] bitCnt_reg, bitCnt_next;
  logic [1:0] byteNum_reg, byteNum_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] low_reg, low_next;
  logic [7:0] high_reg, high_next;
  logic rw_reg, rw_next;
  logic more_reg, more_next;
  logic drive_reg, drive_next;
  logic wr_reg, wr_next;
  logic clr_reg, clr_next;
  logic sclRise, sclFall, startCond, stopCond;
  logic [15:0] rdWord;
  logic [15:0] diagWord;

  assign sclRise = pinsSync.scl && !pinsPrev.scl;
  assign sclFall = !pinsSync.scl && pinsPrev.scl;
  assign startCond = pinsSync.scl && pinsPrev.scl && !pinsSync.sda && pinsPrev.sda;
  assign stopCond = pinsSync.scl && pinsPrev.scl && pinsSync.sda && !pinsPrev.sda;

  always_comb begin
    diagWord = 16'h0000;
    diagWord[`HSPC_DW_SHORTED_BIT] = shorted_reg;
    diagWord[`HSPC_DW_OT_WARN_BIT] = otWarn;
    diagWord[`HSPC_DW_OT_FAULT_BIT] = otFault;
    diagWord[`HSPC_DW_LATCHED_BIT] = latched_reg;
    diagWord[`HSPC_DW_UV_BIT] = !pinsSync.en;
    diagWord[`HSPC_DW_OV_BIT] = pinsSync.ov;
    rdWord = 16'h0000;
    if (cmd_reg == `HSPC_CMD_OPERATION) begin
      rdWord = {8'h00, operation_reg};
    end else if (cmd_reg == `HSPC_CMD_OT_FAULT) begin
      rdWord = otFault_reg;
    end else if (cmd_reg == `HSPC_CMD_OT_WARN) begin
      rdWord = otWarn_reg;
    end else if (cmd_reg == `HSPC_CMD_VENDOR_STATUS) begin
      rdWord = 16'(shorted_reg) << `HSPC_VS_SHORTED_BIT;
    end else if (cmd_reg == `HSPC_CMD_TEMPERATURE) begin
      rdWord = temp_reg;
    end else if (cmd_reg == `HSPC_CMD_ALERT_MASK) begin
      rdWord = alertMask_reg;
    end else if (cmd_reg == `HSPC_CMD_DEVICE_SETUP) begin
      rdWord = {8'h00, setup_reg};
    end else if (cmd_reg == `HSPC_CMD_DIAG_WORD) begin
      rdWord = diagWord;
    end
  end

  always_comb begin
    bus_next = bus_reg;
    shift_next = shift_reg;
    bitCnt_next = bitCnt_reg;
    byteNum_next = byteNum_reg;
    cmd_next = cmd_reg;
    low_next = low_reg;
    high_next = high_reg;
    rw_next = rw_reg;
    more_next = more_reg;
    drive_next = drive_reg;
    wr_next = 1'b0;
    clr_next = 1'b0;
    if (startCond) begin
      bus_next = hspc_pkg::BUS_RX;
      bitCnt_next = 4'h0;
      byteNum_next = 2'h0;
      drive_next = 1'b0;
    end else if (stopCond) begin
      bus_next = hspc_pkg::BUS_IDLE;
      drive_next = 1'b0;
    end else begin
      case (bus_reg)
        hspc_pkg::BUS_RX: begin
          if (sclRise) begin
            shift_next = {shift_reg[6:0], pinsSync.sda};
            bitCnt_next = bitCnt_reg + 4'h1;
          end else if (sclFall && bitCnt_reg == 4'h8) begin
            bitCnt_next = 4'h0;
            bus_next = hspc_pkg::BUS_RXACK;
            drive_next = 1'b1;
            if (byteNum_reg != 2'h3) begin
              byteNum_next = byteNum_reg + 2'h1;
            end
            if (byteNum_reg == 2'h0) begin
              rw_next = shift_reg[0];
              if (!addrValid_reg || shift_reg[7:1] != addr_reg) begin
                bus_next = hspc_pkg::BUS_IDLE;
                drive_next = 1'b0;
              end
              low_next = rdWord[7:0];
              high_next = rdWord[15:8];
            end else if (byteNum_reg == 2'h1) begin
              cmd_next = shift_reg;
              clr_next = shift_reg == `HSPC_CMD_CLEAR_FAULTS;
            end else if (byteNum_reg == 2'h2) begin
              low_next = shift_reg;
              wr_next = cmd_reg == `HSPC_CMD_OPERATION || cmd_reg == `HSPC_CMD_DEVICE_SETUP;
            end else begin
              high_next = shift_reg;
              wr_next = cmd_reg != `HSPC_CMD_OPERATION && cmd_reg != `HSPC_CMD_DEVICE_SETUP;
            end
          end
        end
        hspc_pkg::BUS_RXACK: begin
          if (sclFall) begin
            if (rw_reg) begin
              bus_next = hspc_pkg::BUS_TX;
              drive_next = !low_reg[7];
              shift_next = {low_reg[6:0], 1'b0};
              bitCnt_next = 4'h1;
            end else begin
              bus_next = hspc_pkg::BUS_RX;
              drive_next = 1'b0;
            end
          end
        end
        hspc_pkg::BUS_TX: begin
          if (sclFall) begin
            if (bitCnt_reg == 4'h8) begin
              drive_next = 1'b0;
              bus_next = hspc_pkg::BUS_TXACK;
            end else begin
              drive_next = !shift_reg[7];
              shift_next = {shift_reg[6:0], 1'b0};
              bitCnt_next = bitCnt_reg + 4'h1;
            end
          end
        end
        hspc_pkg::BUS_TXACK: begin
          if (sclRise) begin
            more_next = !pinsSync.sda;
          end else if (sclFall) begin
            if (more_reg) begin
              bus_next = hspc_pkg::BUS_TX;
              drive_next = !high_reg[7];
              shift_next = {high_reg[6:0], 1'b0};
              bitCnt_next = 4'h1;
              high_next = 8'h00;
            end else begin
              bus_next = hspc_pkg::BUS_IDLE;
            end
          end
        end
        default: begin
          drive_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bus_reg <= hspc_pkg::BUS_IDLE;
      shift_reg <= 8'h00;
      bitCnt_reg <= 4'h0;
      byteNum_reg <= 2'h0;
      cmd_reg <= 8'h00;
      low_reg <= 8'h00;
      high_reg <= 8'h00;
      rw_reg <= 1'b0;
      more_reg <= 1'b0;
      drive_reg <= 1'b0;
      wr_reg <= 1'b0;
      clr_reg <= 1'b0;
    end else begin
      bus_reg <= bus_next;
      shift_reg <= shift_next;
      bitCnt_reg <= bitCnt_next;
      byteNum_reg <= byteNum_next;
      cmd_reg <= cmd_next;
      low_reg <= low_next;
      high_reg <= high_next;
      rw_reg <= rw_next;
      more_reg <= more_next;
      drive_reg <= drive_next;
      wr_reg <= wr_next;
      clr_reg <= clr_next;
    end
  end

  assign wrStrobe = wr_reg;
  assign clearStrobe = clr_reg;
  assign wrCmd = cmd_reg;
  assign wrData = {high_reg, low_reg};
  assign sdaOut = 1'b0;
  assign sdaOe = drive_reg;

  // ****************************************
  // Checks
  // ****************************************
  chk_gate_pin_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!pinsSync.en || pinsSync.ov) |=> !gateDrive) else $error("gate on while pins forbid it");
  chk_ot_fault_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (temp_reg > otFault_reg) |=> !gateDrive) else $error("gate on above fault threshold");
  chk_ot_warn_alert: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (otWarn && !alertMask_reg[`HSPC_MASK_OT_WARN_BIT]) |=> smbaOe) else $error("no alert above warning");
  chk_short_flag_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
    shortCond |=> shorted_reg ##1 (smbaOe || alertMask_reg[`HSPC_MASK_SHORTED_BIT]))
    else $error("short not flagged");
  chk_short_flag_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (shorted_reg && !clearStrobe) |=> shorted_reg) else $error("short flag dropped");
  chk_temp_capture: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tempSampleValid |=> (temp_reg == $past(tempSample))) else $error("sample not held");
  chk_latch_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (latched_reg && enRise) |=> !latched_reg) else $error("enable toggle kept latch");
  chk_op_off_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (wrStrobe && wrCmd == `HSPC_CMD_OPERATION && wrData[7:0] == `HSPC_OP_OFF) |=> ##1 !gateDrive)
    else $error("gate on after off write");
  chk_addr_stable: assert property (@(posedge sys_clk) disable iff (!reset_n)
    addrValid_reg |=> (addrValid_reg && $stable(addr_reg))) else $error("address changed");

endmodule

// >>> verif/hspc_smb_host.sv
/*
 SMBus host model for the command slave of the supervision block.
 Assumes a pull-up on SDA: the line is high unless some party pulls it low.
*/
`timescale 1ns/1ps
module hspc_smb_host #(
  parameter logic [6:0] ADDR = 7'h45
) (
  input wire logic sys_clk,
  input wire logic sdaLine,
  output logic sclPin,
  output logic sdaPull
);
  // ****************************************
  // Bus cycles
  // ****************************************
  int nackCount = 0;

  initial begin
    sclPin = 1'b1;
    sdaPull = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // SDA moves 3 clocks after SCL falls, so the slave's synced SCL sees no race
  task automatic bit_io(input logic b, output logic r);
    hold(3);
    sdaPull <= !b;
    hold(7);
    sclPin <= 1'b1;
    hold(5);
    @(negedge sys_clk);
    r = sdaLine;
    hold(5);
    sclPin <= 1'b0;
  endtask

  task automatic byte_io(input logic [7:0] b, input logic ackBit, input logic chkAck, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(ackBit, a);
    if (chkAck && a !== 1'b0) nackCount++;
  endtask

  task automatic start();
    hold(1);
    sdaPull <= 1'b1;
    hold(10);
    sclPin <= 1'b0;
  endtask

  task automatic stop();
    hold(3);
    sdaPull <= 1'b1;
    hold(7);
    sclPin <= 1'b1;
    hold(10);
    sdaPull <= 1'b0;
    hold(10);
  endtask

  // Words go low byte first
  task automatic wr(input logic [7:0] cmd, input logic [15:0] v, input int n);
    logic [7:0] r;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, 1'b1, r);
    byte_io(cmd, 1'b1, 1'b1, r);
    for (int i = 0; i < n; i++) byte_io(v[8*i+:8], 1'b1, 1'b1, r);
    stop();
  endtask

  task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] v);
    logic [7:0] r;
    v = 16'h0000;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, 1'b1, r);
    byte_io(cmd, 1'b1, 1'b1, r);
    hold(3);
    sdaPull <= 1'b0;
    hold(7);
    sclPin <= 1'b1;
    hold(10);
    start();
    byte_io({ADDR, 1'b1}, 1'b1, 1'b1, r);
    for (int i = 0; i < n; i++) begin
      byte_io(8'hff, i == n - 1, 1'b0, r);
      v[8*i+:8] = r;
    end
    stop();
  endtask
endmodule

// >>> verif/hspc_top_bench.sv
/*
 Self-checking bench of the hot-swap supervision block.
 Assumes the host model on SMBus; straps 2,1,0 give address 45h.
*/
`timescale 1ns/1ps
module hspc_top_bench;
  // ****************************************
  // Harness
  // ****************************************
  logic sys_clk, reset_n, sclPin, sdaPull, sdaOe, smbaOe, en, ov, vref;
  logic sense, gateLow, trip, tempValid, diodePulse, gateDrive, latchedOff;
  logic [15:0] temp, d;
  logic [6:0] busAddr;
  logic [5:0] straps;
  int badCount = 0;
  int nCompared = 0;
  wire logic sdaLine = !(sdaPull || sdaOe);

  hspc_top #(.TEMP_PERIOD_CYCLES(20)) hspc_top_inst (.sys_clk, .reset_n, .sclPin, .sdaIn(sdaLine), .sdaOut(),
    .sdaOe, .smbaOut(), .smbaOe, .undervoltEnablePin(en), .overvoltLockoutPin(ov), .vrefAboveCapture(vref),
    .addrStrapBit0(straps[1:0]), .addrStrapBit1(straps[3:2]), .addrStrapBit2(straps[5:4]), .senseAboveShort(sense),
    .gateIsLow(gateLow), .timerTrip(trip), .tempSample(temp), .tempSampleValid(tempValid), .diodePulse,
    .gateDrive, .latchedOff, .busAddr);
  hspc_smb_host #(.ADDR(7'h45)) hspc_smb_host_inst (.sys_clk, .sdaLine, .sclPin, .sdaPull);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    nCompared++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", w, e, g);
      badCount++;
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] v, input int n);
    hspc_smb_host_inst.wr(c, v, n);
    settle(4);
  endtask
  task automatic rd(input logic [7:0] c, input int n);
    hspc_smb_host_inst.rd(c, n, d);
  endtask
  task automatic feed(input logic [15:0] t);
    @(posedge sys_clk) temp <= t;
    tempValid <= 1'b1;
    @(posedge sys_clk) tempValid <= 1'b0;
    settle(6);
  endtask
  task automatic pin_trip();
    @(posedge sys_clk) trip <= 1'b1;
    settle(8);
    @(posedge sys_clk) trip <= 1'b0;
    settle(8);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_boot();
    int n;
    n = 0;
    chk("busAddr", 16'h0045, 16'(busAddr));
    rd(8'h51, 2);
    chk("warnRst", 16'h007d, d);
    rd(8'h4f, 2);
    chk("faultRst", 16'h0096, d);
    repeat (60) begin
      settle(1);
      if (diodePulse === 1'b1) n++;
    end
    chk("pulses", 16'h0003, 16'(n));
    $display("t_boot done");
  endtask

  // Boundaries: equal to a limit is not above it
  task automatic t_temp();
    logic [15:0] tv [5];
    logic [1:0] ev [5];
    tv = '{16'h007d, 16'h007e, 16'h0096, 16'h0097, 16'h0064};
    ev = '{2'b01, 2'b11, 2'b11, 2'b10, 2'b01};
    for (int i = 0; i < 5; i++) begin
      feed(tv[i]);
      chk("alertGate", 16'(ev[i]), 16'({smbaOe, gateDrive}));
    end
    rd(8'h8d, 2);
    chk("temp", 16'h0064, d);
    $display("t_temp done");
  endtask

  task automatic t_limits();
    wr(8'h51, 16'h0032, 2);
    wr(8'h4f, 16'h003c, 2);
    feed(16'h0037);
    chk("alertGate", 16'h0003, 16'({smbaOe, gateDrive}));
    feed(16'h003d);
    chk("alertGate", 16'h0002, 16'({smbaOe, gateDrive}));
    feed(16'h0030);
    @(posedge sys_clk) en <= 1'b0;
    settle(8);
    chk("gateEn", 16'h0000, 16'(gateDrive));
    @(posedge sys_clk) en <= 1'b1;
    @(posedge sys_clk) ov <= 1'b1;
    settle(8);
    chk("gateOv", 16'h0000, 16'(gateDrive));
    @(posedge sys_clk) ov <= 1'b0;
    settle(8);
    chk("gateBack", 16'h0001, 16'(gateDrive));
    rd(8'h51, 2);
    chk("warnKept", 16'h0032, d);
    $display("t_limits done");
  endtask

  task automatic t_short();
    @(posedge sys_clk) sense <= 1'b1;
    settle(8);
    chk("noShort", 16'h0000, 16'(smbaOe));
    // Gate commanded off by the overvoltage pin, not seen low at the pin
    @(posedge sys_clk) ov <= 1'b1;
    settle(8);
    @(posedge sys_clk) sense <= 1'b0;
    ov <= 1'b0;
    settle(8);
    rd(8'h80, 1);
    chk("vendor", 16'h0080, d);
    rd(8'he1, 2);
    chk("diag", 16'h8000, d & 16'h8000);
    chk("alert", 16'h0001, 16'(smbaOe));
    wr(8'h04, 16'h0000, 0);
    chk("cleared", 16'h0000, 16'(smbaOe));
    wr(8'hd8, 16'h0080, 2);
    @(posedge sys_clk) sense <= 1'b1;
    gateLow <= 1'b1;
    settle(8);
    chk("masked", 16'h0000, 16'(smbaOe));
    @(posedge sys_clk) sense <= 1'b0;
    gateLow <= 1'b0;
    wr(8'h04, 16'h0000, 0);
    wr(8'hd8, 16'h0000, 2);
    $display("t_short done");
  endtask

  task automatic t_oper();
    wr(8'h03, 16'h0000, 1);
    chk("gateOff", 16'h0000, 16'(gateDrive));
    wr(8'h03, 16'h0080, 1);
    chk("gateOn", 16'h0001, 16'(gateDrive));
    $display("t_oper done");
  endtask

  // Codes 0..5 allow 0,1,2,4,8,16 retries before the latch
  task automatic t_retry();
    int lim [6];
    lim = '{0, 1, 2, 4, 8, 16};
    for (int k = 0; k < 6; k++) begin
      wr(8'hd9, 16'(k), 1);
      repeat (lim[k]) pin_trip();
      chk("notLatched", 16'h0000, 16'(latchedOff));
      pin_trip();
      chk("latched", 16'h0002, 16'({latchedOff, gateDrive}));
      @(posedge sys_clk) en <= 1'b0;
      settle(8);
      @(posedge sys_clk) en <= 1'b1;
      settle(8);
      chk("released", 16'h0001, 16'({latchedOff, gateDrive}));
    end
    wr(8'hd9, 16'h0006, 1);
    repeat (17) pin_trip();
    chk("unlimited", 16'h0001, 16'({latchedOff, gateDrive}));
    $display("t_retry done");
  endtask

  // Other straps first, then back to the host's own address
  task automatic t_reset();
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk) vref <= 1'b0;
      reset_n <= 1'b0;
      straps <= (k == 0) ? 6'h2a : 6'h06;
      settle(3);
      @(posedge sys_clk) reset_n <= 1'b1;
      settle(6);
      chk("addrHeld", 16'h0000, 16'(busAddr));
      @(posedge sys_clk) vref <= 1'b1;
      settle(8);
      chk("addr", (k == 0) ? 16'h005a : 16'h0045, 16'(busAddr));
    end
    rd(8'h51, 2);
    chk("warnRst", 16'h007d, d);
    chk("nacks", 16'h0000, 16'(hspc_smb_host_inst.nackCount));
    $display("t_reset done");
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    en = 1'b1;
    ov = 1'b0;
    vref = 1'b1;
    sense = 1'b0;
    gateLow = 1'b0;
    trip = 1'b0;
    temp = 16'h0000;
    tempValid = 1'b0;
    straps = 6'h06;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    settle(10);
    t_boot();
    t_temp();
    t_limits();
    t_short();
    t_oper();
    t_retry();
    t_reset();
    close_out();
  end

  // About three times the expected run
  initial begin
    repeat (50000) @(posedge sys_clk);
    badCount++;
    $display("[ERR] watchdog exp done got hang");
    close_out();
  end
endmodule
